// >>> rtl/iod_indexed_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - extended mode: operand offsets index pointer two
// - offset form only for operand at most 5Fh
// - offset form only with access bit clear
// - destination bit unchanged in offset mode
// - indexed add sums accumulator, sets N OV C DC Z
// - d=0 writes accumulator, d=1 writes memory
// - legacy mode: access bank or bank select
// - pointer zero restores legacy access addresses
module iod_indexed_decode
    import iod_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Instruction issue
    input wire logic instrValid,
    input wire logic [INSTR_W-1:0] instrWord,
    input wire logic extEnable,
    // Core registers
    input wire logic [ADDR_W-1:0] indexPointerTwo,
    input wire logic [3:0] bankSelectReg,
    // Data memory
    output logic memAddrValid,
    output logic [ADDR_W-1:0] memAddr,
    input wire logic [DATA_W-1:0] memRdata,
    output logic memWe,
    output logic [DATA_W-1:0] memWdata,
    // Architectural results and progress
    output logic [DATA_W-1:0] accumulator,
    output logic [5:0] statusFlags,
    output logic indexedMode,
    output logic busy,
    output logic [1:0] phase
);
    typedef struct packed {
        iod_phase_t ph;
        logic active;
        logic dest;
        logic isAdd;
        logic indexed;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] operand;
        logic [DATA_W-1:0] result;
        logic [DATA_W-1:0] acc;
        logic [5:0] flags;
        logic we;
        logic [DATA_W-1:0] wdata;
    } iod_state_t;

    iod_state_t st_q, st_d;
    logic [ADDR_W-1:0] calcAddr;
    logic calcIndexed;
    logic takeInstr;

    // Arithmetic helpers for the add, kept as functions so the flag rules sit in one place
    function automatic logic op_is_add(
        input logic [INSTR_W-1:0] word
    );
        logic [INSTR_W-OPC_LSB-1:0] opc;
        opc = word[INSTR_W-1:OPC_LSB];
        return opc == OPC_ADD;
    endfunction

    function automatic logic nibble_carry(
        input logic [3:0] a,
        input logic [3:0] b
    );
        logic [4:0] low;
        low = {1'b0, a} + {1'b0, b};
        return low[4];
    endfunction

    function automatic logic [DATA_W-1:0] add_result(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b
    );
        logic [DATA_W:0] total;
        total = {1'b0, a} + {1'b0, b};
        return total[DATA_W-1:0];
    endfunction

    // Status word of an add; the spare bit records which destination was chosen
    function automatic logic [5:0] add_flags(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic dest
    );
        logic [DATA_W:0] total;
        logic [5:0] f;
        total = {1'b0, a} + {1'b0, b};
        f = '0;
        f[FLAG_C] = total[DATA_W];
        f[FLAG_DC] = nibble_carry(a[3:0], b[3:0]);
        f[FLAG_Z] = (total[DATA_W-1:0] == '0);
        f[FLAG_N] = total[DATA_W-1];
        // Overflow: both inputs share a sign that the sum lacks
        f[FLAG_OV] = (a[DATA_W-1] == b[DATA_W-1])
            && (total[DATA_W-1] != a[DATA_W-1]);
        f[FLAG_W] = dest;
        return f;
    endfunction

    // Only an add with the destination bit set writes data memory
    function automatic logic write_to_memory(input logic isAdd, input logic dest);
        return isAdd && dest;
    endfunction

    // Fixed four-phase sequence: every instruction spends one cycle in each
    function automatic iod_phase_t next_phase(
        input iod_phase_t p
    );
        iod_phase_t n;
        n = IOD_DECODE;
        case (p)
            IOD_DECODE: begin
                n = IOD_READ;
            end
            IOD_READ: begin
                n = IOD_PROCESS;
            end
            IOD_PROCESS: begin
                n = IOD_WRITE;
            end
            IOD_WRITE: begin
                n = IOD_DECODE;
            end
            default: begin
                n = IOD_DECODE;
            end
        endcase
        return n;
    endfunction

    // Operand address path, purely combinational
    iod_addr_calc u_addr (
        .fileOperand(instrWord[7:0]),
        .accessBit(instrWord[ACCESS_BIT]),
        .extEnable(extEnable),
        .indexPointerTwo(indexPointerTwo),
        .bankSelectReg(bankSelectReg),
        .effAddr(calcAddr),
        .indexedMode(calcIndexed)
    );

    // A word offered outside Q1 is ignored without any indication
    assign takeInstr = instrValid && (st_q.ph == IOD_DECODE);

    always_comb begin
        st_d = st_q;
        st_d.we = 1'b0;
        case (st_q.ph)
            IOD_DECODE: begin
                // Q1: latch address, mode and opcode of the new word
                if (takeInstr) begin
                    st_d.active = 1'b1;
                    st_d.addr = calcAddr;
                    st_d.indexed = calcIndexed;
                    st_d.dest = instrWord[DEST_BIT];
                    st_d.isAdd = op_is_add(instrWord);
                    st_d.ph = next_phase(st_q.ph);
                end
            end
            IOD_READ: begin
                // Q2: the memory answers the address within this cycle
                st_d.operand = memRdata;
                st_d.ph = next_phase(st_q.ph);
            end
            IOD_PROCESS: begin
                // Q3: result and flags are formed; nothing is written yet
                if (st_q.isAdd) begin
                    st_d.result = add_result(st_q.acc, st_q.operand);
                    st_d.flags = add_flags(st_q.acc, st_q.operand, st_q.dest);
                end
                st_d.ph = next_phase(st_q.ph);
            end
            IOD_WRITE: begin
                // Only the add is executed here; other opcodes only exercise addressing
                if (write_to_memory(st_q.isAdd, st_q.dest)) begin
                    st_d.we = 1'b1;
                    st_d.wdata = st_q.result;
                end else if (st_q.isAdd) begin
                    st_d.acc = st_q.result;
                end
                st_d.active = 1'b0;
                st_d.ph = next_phase(st_q.ph);
            end
            default: begin
                st_d.ph = IOD_DECODE;
            end
        endcase
    end

    // Synchronous reset clears every field, so all outputs read zero after it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Memory side; the read strobe comes straight from the phase so it never lags the address
    assign memAddrValid = st_q.ph == IOD_READ;
    assign memAddr = st_q.addr;
    assign memWe = st_q.we;
    assign memWdata = st_q.wdata;

    // Architectural state
    assign accumulator = st_q.acc;
    assign statusFlags = st_q.flags;
    assign indexedMode = st_q.indexed;

    // Progress
    assign busy = st_q.active;
    assign phase = st_q.ph;
endmodule // iod_indexed_decode
`default_nettype wire

// >>> rtl/iod_pkg.sv
package iod_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int INSTR_W = 16;
    // Offset mode applies to operand values at or below this limit
    localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
    // Access-bank split: low part maps to bank 0, high part to the SFR bank
    localparam logic [3:0] SFR_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    // Byte-oriented add opcode: bits 15:10
    localparam logic [5:0] OPC_ADD = 6'h09;
    localparam int OPC_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    // Flag vector bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int FLAG_W = 5;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q3 = 2'h2;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    typedef enum logic [1:0] {
        IOD_DECODE,
        IOD_READ,
        IOD_PROCESS,
        IOD_WRITE
    } iod_phase_t;
endpackage

// >>> rtl/iod_addr_calc.sv
`timescale 1ns/1ps
`default_nettype none
module iod_addr_calc
    import iod_pkg::*;
(
    // Operand fields
    input wire logic [7:0] fileOperand,
    input wire logic accessBit,
    // Mode and pointers
    input wire logic extEnable,
    input wire logic [ADDR_W-1:0] indexPointerTwo,
    input wire logic [3:0] bankSelectReg,
    // Result
    output logic [ADDR_W-1:0] effAddr,
    output logic indexedMode
);
    always_comb begin
        indexedMode = extEnable && !accessBit && (fileOperand <= OFFSET_LIMIT);
        if (indexedMode) begin
            // With the pointer at zero this lands on the old access-RAM low range
            effAddr = indexPointerTwo + {4'h0, fileOperand};
        end else if (accessBit) begin
            effAddr = {bankSelectReg, fileOperand};
        end else if (fileOperand <= OFFSET_LIMIT) begin
            effAddr = {ACCESS_LOW_BANK, fileOperand};
        end else begin
            effAddr = {SFR_BANK, fileOperand};
        end
    end
endmodule // iod_addr_calc
`default_nettype wire

// >>> tb/iod_indexed_decode_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iod_indexed_decode_chk
    import iod_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic resetn,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic extEnable,
    input wire logic [11:0] indexPointerTwo,
    input wire logic [3:0] bankSelectReg,
    input wire logic [11:0] memAddr,
    input wire logic [7:0] memRdata,
    input wire logic memWe,
    input wire logic [7:0] memWdata,
    input wire logic [7:0] accumulator,
    input wire logic [5:0] statusFlags,
    input wire logic indexedMode,
    input wire logic busy,
    input wire logic [1:0] phase
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire take = phase == PHASE_Q1 && instrValid;
    wire addOp = take && instrWord[15:10] == OPC_ADD;
    wire lowOp = !instrWord[ACCESS_BIT] && instrWord[7:0] <= OFFSET_LIMIT;
    sequence busyRun;
        busy [*3] ##1 !busy;
    endsequence
    chk_phase_step: assert property (take |=> phase == PHASE_Q2) else $error("phase");
    chk_busy_run: assert property (take |=> busyRun) else $error("busy");
    chk_offset_addr: assert property (take && extEnable && lowOp |=> indexedMode &&
        memAddr == $past(indexPointerTwo) + {4'h0, $past(instrWord[7:0])}) else $error("offset");
    chk_bank_addr: assert property (take && instrWord[ACCESS_BIT] |=> !indexedMode &&
        memAddr == {$past(bankSelectReg), $past(instrWord[7:0])}) else $error("bank");
    chk_dest_acc: assert property (addOp && !instrWord[DEST_BIT] |=> ##3 !memWe &&
        accumulator == $past(accumulator, 4) + $past(memRdata, 3)) else $error("acc");
    chk_dest_mem: assert property (addOp && instrWord[DEST_BIT] |=> ##3 memWe &&
        memWdata == $past(accumulator, 4) + $past(memRdata, 3)) else $error("wdata");
    chk_zero_flag: assert property (memWe |-> statusFlags[FLAG_Z] == (memWdata == 8'h00)) else $error("z");
    chk_we_pulse: assert property (memWe |=> !memWe) else $error("we");
endmodule // iod_indexed_decode_chk
bind iod_indexed_decode iod_indexed_decode_chk chk (.*);
`default_nettype wire

// >>> tb/test_indexed_offset_operand_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_indexed_offset_operand_decode;
    import iod_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, instrValid = 1'b0, extEnable = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [11:0] indexPointerTwo = 12'h000, memAddr;
    logic [3:0] bankSelectReg = 4'h3;
    logic [7:0] memRdata = 8'h00, memWdata, accumulator, acc = 8'h00;
    logic [5:0] statusFlags;
    logic memAddrValid, memWe, indexedMode, busy;
    logic [1:0] phase;
    logic [8:0] sum;
    logic [5:0] flg;
    int failures = 0, n_checks = 0, cyc = 0;
    iod_indexed_decode uut (.*);
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 400) begin
            failures++;
            results();
        end
    end
    task results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // One add, entered at a falling edge in phase 0; back to back with the next
    task op(input logic e, input logic [11:0] p, input logic [9:0] da, input logic [7:0] rd,
            input logic [11:0] ea, input logic ix);
        extEnable = e;
        indexPointerTwo = p;
        instrWord = {OPC_ADD, da};
        instrValid = 1'b1;
        @(negedge mclk);
        instrValid = 1'b0;
        memRdata = rd;
        chk("addr", ea, memAddr);
        chk("mode", {11'h0, ix}, {11'h0, indexedMode});
        chk("valid", 12'h001, {11'h0, memAddrValid});
        @(negedge mclk);
        memRdata = ~rd;
        repeat (2) @(negedge mclk);
        sum = acc + rd;
        flg = {da[9], sum[7], (acc[7] == rd[7]) && (sum[7] != acc[7]), sum[7:0] == 8'h00,
               ({1'b0, acc[3:0]} + {1'b0, rd[3:0]}) > 5'h0F, sum[8]};
        chk("we", {11'h0, da[9]}, {11'h0, memWe});
        if (da[9]) chk("wdata", {4'h0, sum[7:0]}, {4'h0, memWdata});
        else acc = sum[7:0];
        chk("acc", {4'h0, acc}, {4'h0, accumulator});
        chk("flags", {6'h0, flg}, {6'h0, statusFlags});
    endtask
    task t_example;
        op(1'b0, 12'hA00, 10'h120, 8'h17, 12'h320, 1'b0);
        op(1'b1, 12'hA00, 10'h02C, 8'h20, 12'hA2C, 1'b1);
        $display("example done");
    endtask
    task t_modes;
        op(1'b1, 12'hFF0, 10'h25F, 8'hC9, 12'h04F, 1'b1);
        op(1'b1, 12'hA00, 10'h060, 8'h01, 12'hF60, 1'b0);
        op(1'b1, 12'h000, 10'h010, 8'h01, 12'h010, 1'b1);
        op(1'b1, 12'hA00, 10'h110, 8'h01, 12'h310, 1'b0);
        op(1'b0, 12'hA00, 10'h010, 8'h01, 12'h010, 1'b0);
        $display("modes done");
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        t_example();
        t_modes();
        results();
    end
endmodule // test_indexed_offset_operand_decode
`default_nettype wire
